/* design/ifeb_intc.sv */
// Functional notes
// - Unimplemented flag and enable bits ignore writes and read back zero.
// - Implemented flag and enable bits are software read/write and reset to zero.
// - A flag reads one once its source requested, zero otherwise.
// - An enable of one passes its source's request on; zero blocks it.
// - Flag register 0 high byte: ADC done bit 13 down to timer three bit 8.
// - Flag register 0 low byte: timer two bit 7 to ext pin zero bit 0, bit 4 empty.
// - Flag register 1 holds ext pin two, captures 8/7, ext pin one, change, I2C.
// - Flag register 3: PWM one fault bit 15, encoder bit 10, PWM one error bit 9.
// - Flag register 4: PWM two fault bit 10, PWM two error bit 9, serial error bit 1.
// - Enable register 0 mirrors flag register 0 layout; bits 15-14 and 4 empty.
// - Three-bit priority per source; 111 highest, 000 disables the source.
// - External pin flags set on falling edge when polarity is one, else rising.
//
// The APB slave port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
`default_nettype none

module ifeb_intc
	import ifeb_pkg::*;
(
	// Clock and reset
	input  wire logic                            ref_clk,
	input  wire logic                            reset_n,
	// APB slave
	input  wire logic                            psel,
	input  wire logic                            penable,
	input  wire logic                            pwrite,
	input  wire logic [ADDR_W-1:0]               paddr,
	input  wire logic [DATA_W-1:0]               pwdata,
	input  wire logic [3:0]                      pstrb,
	output logic      [DATA_W-1:0]               prdata,
	output logic                                 pready,
	output logic                                 pslverr,
	// Peripheral request pulses, banks in order of flag registers 0, 1, 3, 4
	input  wire logic [NUM_BANKS-1:0][REG_W-1:0] periphReq,
	// External interrupt pins
	input  wire logic [NUM_EXT-1:0]              extPin,
	// Processor side
	output logic                                 irq,
	output logic      [SRC_IDX_W-1:0]            irqSource,
	output logic      [PRIO_W-1:0]               irqLevel
);

	////////////////////////////////////////////////////////////////////////////////
	// State

	ifeb_bus_state_t                 busState;
	ifeb_bus_state_t                 next_busState;
	logic [NUM_BANKS-1:0][REG_W-1:0] flag;
	logic [NUM_BANKS-1:0][REG_W-1:0] next_flag;
	logic [NUM_BANKS-1:0][REG_W-1:0] enable;
	logic [NUM_BANKS-1:0][REG_W-1:0] next_enable;
	logic [NUM_EXT-1:0]              polarity;
	logic [NUM_EXT-1:0]              next_polarity;
	logic [PRIO_W-1:0]               prio      [NUM_SRC];
	logic [PRIO_W-1:0]               next_prio [NUM_SRC];
	logic [DATA_W-1:0]               next_prdata;
	logic                            next_pready;
	logic                            next_pslverr;
	logic                            next_irq;
	logic [SRC_IDX_W-1:0]            next_irqSource;
	logic [PRIO_W-1:0]               next_irqLevel;

	// Decode and event wires
	logic                            flagHit;
	logic                            enableHit;
	logic                            polHit;
	logic                            prioHit;
	logic                            anyHit;
	logic [1:0]                      bank;
	logic [3:0]                      prioReg;
	logic                            wrFire;
	logic [REG_W-1:0]                laneMask;
	logic [REG_W-1:0]                wrData;
	logic [NUM_EXT-1:0]              extPulse;
	logic [NUM_BANKS-1:0][REG_W-1:0] event_;
	localparam logic [NUM_SRC-1:0]   IMPL_FLAT = IMPL_MASK;

	ifeb_arb_if arb ();

	////////////////////////////////////////////////////////////////////////////////
	// Address decode; anything not listed is unmapped and answers with an error

	always_comb
	begin
		flagHit   = 1'b0;
		enableHit = 1'b0;
		polHit    = 1'b0;
		prioHit   = 1'b0;
		bank      = 2'h0;
		prioReg   = paddr[5:2];
		case (paddr)
			OFF_FLAG0:    begin flagHit = 1'b1;   bank = 2'h0; end
			OFF_FLAG1:    begin flagHit = 1'b1;   bank = 2'h1; end
			OFF_FLAG3:    begin flagHit = 1'b1;   bank = 2'h2; end
			OFF_FLAG4:    begin flagHit = 1'b1;   bank = 2'h3; end
			OFF_ENABLE0:  begin enableHit = 1'b1; bank = 2'h0; end
			OFF_ENABLE1:  begin enableHit = 1'b1; bank = 2'h1; end
			OFF_ENABLE3:  begin enableHit = 1'b1; bank = 2'h2; end
			OFF_ENABLE4:  begin enableHit = 1'b1; bank = 2'h3; end
			OFF_POLARITY: polHit = 1'b1;
			default:      prioHit = (paddr[ADDR_W-1:6] == OFF_PRIO_BASE[ADDR_W-1:6]) && (paddr[1:0] == 2'h0);
		endcase
		anyHit = flagHit | enableHit | polHit | prioHit;
	end

	// A write lands only at the edge where the answer is given
	assign wrFire   = (busState == BUS_RESPOND) & psel & penable & pwrite & anyHit;
	assign laneMask = {{8{pstrb[1]}}, {8{pstrb[0]}}};
	assign wrData   = pwdata[REG_W-1:0];

	////////////////////////////////////////////////////////////////////////////////
	// Bus slave: one wait state, then pready with data registered alongside

	always_comb
	begin
		next_busState = BUS_IDLE;
		next_pready   = 1'b0;
		next_pslverr  = 1'b0;
		next_prdata   = '0;
		case (busState)
			BUS_IDLE:
			begin
				if (psel && penable)
				begin
					next_busState = BUS_RESPOND;
					next_pready   = 1'b1;
					next_pslverr  = ~anyHit;
					if (!pwrite && flagHit)
						next_prdata = DATA_W'(flag[bank] & IMPL_MASK[bank]);
					else if (!pwrite && enableHit)
						next_prdata = DATA_W'(enable[bank] & IMPL_MASK[bank]);
					else if (!pwrite && polHit)
						next_prdata = DATA_W'(polarity);
					else if (!pwrite && prioHit)
					begin
						for (int k = 0; k < 4; k++)
							next_prdata[4*k +: PRIO_W] = prio[{prioReg, 2'(k)}];
					end
				end
			end
			BUS_RESPOND:
				next_busState = BUS_IDLE;
			default:
				next_busState = BUS_IDLE;
		endcase
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			busState <= BUS_IDLE;
			pready   <= 1'b0;
			pslverr  <= 1'b0;
			prdata   <= '0;
		end
		else
		begin
			busState <= next_busState;
			pready   <= next_pready;
			pslverr  <= next_pslverr;
			prdata   <= next_prdata;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// External pins: one edge detector each, edge chosen by its polarity bit

	ifeb_edge_detect uExtZero
	(
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.pinLevel    (extPin[0]),
		.fallingEdge (polarity[EXT_ZERO_POL_BIT]),
		.edgePulse   (extPulse[0])
	);

	ifeb_edge_detect uExtOne
	(
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.pinLevel    (extPin[1]),
		.fallingEdge (polarity[EXT_ONE_POL_BIT]),
		.edgePulse   (extPulse[1])
	);

	ifeb_edge_detect uExtTwo
	(
		.ref_clk     (ref_clk),
		.reset_n     (reset_n),
		.pinLevel    (extPin[2]),
		.fallingEdge (polarity[EXT_TWO_POL_BIT]),
		.edgePulse   (extPulse[2])
	);

	// Gather peripheral pulses and pin edges into per-bank events
	always_comb
	begin
		event_ = periphReq;
		event_[EXT_ZERO_BANK][EXT_ZERO_BIT] = periphReq[EXT_ZERO_BANK][EXT_ZERO_BIT] | extPulse[0];
		event_[EXT_ONE_BANK][EXT_ONE_BIT]   = periphReq[EXT_ONE_BANK][EXT_ONE_BIT] | extPulse[1];
		event_[EXT_TWO_BANK][EXT_TWO_BIT]   = periphReq[EXT_TWO_BANK][EXT_TWO_BIT] | extPulse[2];
	end

	////////////////////////////////////////////////////////////////////////////////
	// Flags, enables and polarity; an event in the cycle of a clearing write still sets the flag

	always_comb
	begin
		next_flag     = flag;
		next_enable   = enable;
		next_polarity = polarity;
		for (int b = 0; b < NUM_BANKS; b++)
		begin
			if (wrFire && flagHit && (bank == 2'(b)))
				next_flag[b] = (flag[b] & ~laneMask) | (wrData & laneMask);
			if (wrFire && enableHit && (bank == 2'(b)))
				next_enable[b] = (enable[b] & ~laneMask) | (wrData & laneMask);
			// Masks place every flag at its documented bit and drop unused positions
			next_flag[b]   = (next_flag[b] | event_[b]) & IMPL_MASK[b];
			next_enable[b] = next_enable[b] & IMPL_MASK[b];
		end
		if (wrFire && polHit && pstrb[0])
			next_polarity = wrData[NUM_EXT-1:0];
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int b = 0; b < NUM_BANKS; b++)
			begin
				flag[b]   <= FLAG_RESET;
				enable[b] <= ENABLE_RESET;
			end
			polarity <= POL_RESET;
		end
		else
		begin
			flag     <= next_flag;
			enable   <= next_enable;
			polarity <= next_polarity;
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Priority fields, four per register in bits 2:0, 6:4, 10:8, 14:12

	always_comb
	begin
		for (int i = 0; i < NUM_SRC; i++)
			next_prio[i] = prio[i];
		if (wrFire && prioHit)
		begin
			for (int k = 0; k < 4; k++)
			begin
				// Fields of absent sources stay zero so they read back as zero
				if (((k < 2) ? pstrb[0] : pstrb[1]) && IMPL_FLAT[{prioReg, 2'(k)}])
					next_prio[{prioReg, 2'(k)}] = wrData[4*k +: PRIO_W];
			end
		end
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			for (int i = 0; i < NUM_SRC; i++)
				prio[i] <= IMPL_FLAT[i] ? PRIO_RESET : PRIO_DISABLED; // Constant per source, safe in async reset
		end
		else
		begin
			for (int i = 0; i < NUM_SRC; i++)
				prio[i] <= next_prio[i];
		end
	end

	////////////////////////////////////////////////////////////////////////////////
	// Request selection toward the processor

	always_comb
	begin
		arb.pending = flag & enable;
		for (int i = 0; i < NUM_SRC; i++)
			arb.level[i] = prio[i];
	end

	ifeb_prio_arb uArb
	(
		.arb (arb.arbiter)
	);

	// A source at level zero never wins, so it cannot raise irq
	always_comb
	begin
		next_irq       = arb.found;
		next_irqSource = arb.winner;
		next_irqLevel  = arb.winLevel;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			irq       <= 1'b0;
			irqSource <= '0;
			irqLevel  <= PRIO_DISABLED;
		end
		else
		begin
			irq       <= next_irq;
			irqSource <= next_irqSource;
			irqLevel  <= next_irqLevel;
		end
	end

endmodule

`default_nettype wire

/* design/ifeb_pkg.sv */
package ifeb_pkg;

	// Widths and counts
	localparam int ADDR_W        = 12;
	localparam int DATA_W        = 32;
	localparam int REG_W         = 16;
	localparam int NUM_BANKS     = 4;
	localparam int NUM_SRC       = NUM_BANKS * REG_W;
	localparam int SRC_IDX_W     = 6;
	localparam int PRIO_W        = 3;
	localparam int NUM_PRIO_REGS = 16;
	localparam int NUM_EXT       = 3;

	// Register byte offsets; banks 0..3 hold flag/enable registers 0, 1, 3 and 4
	localparam logic [ADDR_W-1:0] OFF_FLAG0     = 12'h000;
	localparam logic [ADDR_W-1:0] OFF_FLAG1     = 12'h004;
	localparam logic [ADDR_W-1:0] OFF_FLAG3     = 12'h00c;
	localparam logic [ADDR_W-1:0] OFF_FLAG4     = 12'h010;
	localparam logic [ADDR_W-1:0] OFF_ENABLE0   = 12'h020;
	localparam logic [ADDR_W-1:0] OFF_ENABLE1   = 12'h024;
	localparam logic [ADDR_W-1:0] OFF_ENABLE3   = 12'h02c;
	localparam logic [ADDR_W-1:0] OFF_ENABLE4   = 12'h030;
	localparam logic [ADDR_W-1:0] OFF_POLARITY  = 12'h040;
	localparam logic [ADDR_W-1:0] OFF_PRIO_BASE = 12'h080;

	// Flag register 0 bit positions
	localparam int ADC_DONE_BIT    = 13;
	localparam int SERIAL_TX_BIT   = 12;
	localparam int SERIAL_RX_BIT   = 11;
	localparam int SPI_EVENT_BIT   = 10;
	localparam int SPI_FAULT_BIT   = 9;
	localparam int TIMER_THREE_BIT = 8;
	localparam int TIMER_TWO_BIT   = 7;
	localparam int COMPARE_TWO_BIT = 6;
	localparam int CAPTURE_TWO_BIT = 5;
	localparam int TIMER_ONE_BIT   = 3;
	localparam int COMPARE_ONE_BIT = 2;
	localparam int CAPTURE_ONE_BIT = 1;
	localparam int EXT_ZERO_BIT    = 0;
	// Flag register 1 bit positions
	localparam int EXT_TWO_BIT       = 13;
	localparam int CAPTURE_EIGHT_BIT = 7;
	localparam int CAPTURE_SEVEN_BIT = 6;
	localparam int EXT_ONE_BIT       = 4;
	localparam int CHANGE_NOTIFY_BIT = 3;
	localparam int I2C_MASTER_BIT    = 1;
	localparam int I2C_SLAVE_BIT     = 0;
	// Flag register 3 bit positions
	localparam int PWM_ONE_FAULT_BIT = 15;
	localparam int ENCODER_EVENT_BIT = 10;
	localparam int PWM_ONE_ERROR_BIT = 9;
	// Flag register 4 bit positions
	localparam int PWM_TWO_FAULT_BIT = 10;
	localparam int PWM_TWO_ERROR_BIT = 9;
	localparam int SERIAL_ERROR_BIT  = 1;

	// Banks that carry the external pin flags
	localparam int EXT_ZERO_BANK = 0;
	localparam int EXT_ONE_BANK  = 1;
	localparam int EXT_TWO_BANK  = 1;

	// Polarity register bit positions
	localparam int EXT_ZERO_POL_BIT = 0;
	localparam int EXT_ONE_POL_BIT  = 1;
	localparam int EXT_TWO_POL_BIT  = 2;

	// Implemented-bit masks, built from the positions above
	localparam logic [REG_W-1:0] IMPL_MASK0 = REG_W'((1 << ADC_DONE_BIT) | (1 << SERIAL_TX_BIT)
		| (1 << SERIAL_RX_BIT) | (1 << SPI_EVENT_BIT) | (1 << SPI_FAULT_BIT) | (1 << TIMER_THREE_BIT)
		| (1 << TIMER_TWO_BIT) | (1 << COMPARE_TWO_BIT) | (1 << CAPTURE_TWO_BIT) | (1 << TIMER_ONE_BIT)
		| (1 << COMPARE_ONE_BIT) | (1 << CAPTURE_ONE_BIT) | (1 << EXT_ZERO_BIT));
	localparam logic [REG_W-1:0] IMPL_MASK1 = REG_W'((1 << EXT_TWO_BIT) | (1 << CAPTURE_EIGHT_BIT)
		| (1 << CAPTURE_SEVEN_BIT) | (1 << EXT_ONE_BIT) | (1 << CHANGE_NOTIFY_BIT)
		| (1 << I2C_MASTER_BIT) | (1 << I2C_SLAVE_BIT));
	localparam logic [REG_W-1:0] IMPL_MASK3 = REG_W'((1 << PWM_ONE_FAULT_BIT) | (1 << ENCODER_EVENT_BIT)
		| (1 << PWM_ONE_ERROR_BIT));
	localparam logic [REG_W-1:0] IMPL_MASK4 = REG_W'((1 << PWM_TWO_FAULT_BIT) | (1 << PWM_TWO_ERROR_BIT)
		| (1 << SERIAL_ERROR_BIT));
	localparam logic [NUM_BANKS-1:0][REG_W-1:0] IMPL_MASK = {IMPL_MASK4, IMPL_MASK3, IMPL_MASK1, IMPL_MASK0};

	// Reset values
	localparam logic [REG_W-1:0]  FLAG_RESET     = 16'h0000;
	localparam logic [REG_W-1:0]  ENABLE_RESET   = 16'h0000;
	localparam logic [NUM_EXT-1:0] POL_RESET     = 3'h0;
	localparam logic [PRIO_W-1:0] PRIO_RESET     = 3'h4;
	localparam logic [PRIO_W-1:0] PRIO_DISABLED  = 3'h0;

	// Bus slave states
	typedef enum logic [0:0]
	{
		BUS_IDLE    = 1'b0,
		BUS_RESPOND = 1'b1
	} ifeb_bus_state_t;

endpackage

/* design/ifeb_arb_if.sv */
`timescale 1ns/100ps
`default_nettype none

interface ifeb_arb_if;
	import ifeb_pkg::*;

	logic [NUM_SRC-1:0]    pending;
	logic [PRIO_W-1:0]     level [NUM_SRC];
	logic                  found;
	logic [SRC_IDX_W-1:0]  winner;
	logic [PRIO_W-1:0]     winLevel;

	modport requester (output pending, output level, input found, input winner, input winLevel);
	modport arbiter   (input pending, input level, output found, output winner, output winLevel);

endinterface

`default_nettype wire

/* design/ifeb_edge_detect.sv */
`timescale 1ns/100ps
`default_nettype none

module ifeb_edge_detect
	import ifeb_pkg::*;
(
	// Clock and reset
	input  wire logic ref_clk,
	input  wire logic reset_n,
	// Pin and edge choice
	input  wire logic pinLevel,
	input  wire logic fallingEdge,
	// Result
	output logic      edgePulse
);

	logic prevLevel;
	logic primed;
	logic next_prevLevel;
	logic next_primed;

	////////////////////////////////////////////////////////////////////////////////
	// Edge compare; the first sample after reset only primes, so a pin already high is no edge
	always_comb
	begin
		next_prevLevel = pinLevel;
		next_primed    = 1'b1;
		if (!primed)
			edgePulse = 1'b0;
		else if (fallingEdge)
			edgePulse = prevLevel & ~pinLevel;
		else
			edgePulse = ~prevLevel & pinLevel;
	end

	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			prevLevel <= 1'b0;
			primed    <= 1'b0;
		end
		else
		begin
			prevLevel <= next_prevLevel;
			primed    <= next_primed;
		end
	end

endmodule

`default_nettype wire

/* design/ifeb_prio_arb.sv */
`timescale 1ns/100ps
`default_nettype none

module ifeb_prio_arb
	import ifeb_pkg::*;
(
	// Requests in, winner out
	ifeb_arb_if.arbiter arb
);

	////////////////////////////////////////////////////////////////////////////////
	// Highest level wins; strict compare keeps the lowest index on ties and never picks level zero
	always_comb
	begin
		arb.found    = 1'b0;
		arb.winner   = '0;
		arb.winLevel = PRIO_DISABLED;
		for (int i = 0; i < NUM_SRC; i++)
		begin
			if (arb.pending[i] && (arb.level[i] > arb.winLevel))
			begin
				arb.found    = 1'b1;
				arb.winner   = SRC_IDX_W'(i);
				arb.winLevel = arb.level[i];
			end
		end
	end

endmodule

`default_nettype wire

/* sim/ifeb_intc_properties.sv */
`timescale 1ns/100ps
`default_nettype none

module ifeb_intc_props
	import ifeb_pkg::*;
(
	// Clock and reset
	input wire logic                 ref_clk,
	input wire logic                 reset_n,
	// Bus side
	input wire logic                 psel,
	input wire logic                 penable,
	input wire logic [ADDR_W-1:0]    paddr,
	input wire logic [DATA_W-1:0]    prdata,
	input wire logic                 pready,
	input wire logic                 pslverr,
	// Processor side
	input wire logic                 irq,
	input wire logic [SRC_IDX_W-1:0] irqSource,
	input wire logic [PRIO_W-1:0]    irqLevel
);
	default clocking cb @(posedge ref_clk); endclocking
	default disable iff (!reset_n);

	////////////////////////////////////////////////////////////////
	// Bus answer shape: one wait state, one-cycle answer
	property p_readyNext; psel && penable && !pready |=> pready; endproperty
	property p_readyOne; $rose(pready) |=> $fell(pready); endproperty
	property p_upperZero; pready |-> prdata[31:16] == 16'h0000; endproperty
	property p_unmapped; psel && penable && !pready && paddr == 12'h008 |=> pslverr && prdata == 32'h0; endproperty
	property p_errWithReady; pslverr |-> pready; endproperty
	a_readyNext: assert property (p_readyNext) else $error("no answer one cycle after access");
	a_readyOne: assert property (p_readyOne) else $error("answer held too long");
	a_upperZero: assert property (p_upperZero) else $error("upper read half not zero");
	a_unmapped: assert property (p_unmapped) else $error("unmapped access not refused");
	a_errWithReady: assert property (p_errWithReady) else $error("error without answer");

	////////////////////////////////////////////////////////////////
	// Request output: a level of zero never wins, absent sources never win
	property p_levelNonZero; irq |-> irqLevel != 3'h0; endproperty
	property p_quietLevel; !irq |-> irqLevel == 3'h0; endproperty
	property p_implSource; irq |-> IMPL_MASK[irqSource[5:4]][irqSource[3:0]]; endproperty
	a_levelNonZero: assert property (p_levelNonZero) else $error("request at level zero");
	a_quietLevel: assert property (p_quietLevel) else $error("level shown without request");
	a_implSource: assert property (p_implSource) else $error("unimplemented source requests");

	// Main scenarios seen
	c_answer: cover property (pready && !pslverr);
	c_refused: cover property (pslverr);
	c_request: cover property ($rose(irq));
endmodule

bind ifeb_intc ifeb_intc_props chk_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable),
	.paddr(paddr), .prdata(prdata), .pready(pready), .pslverr(pslverr), .irq(irq), .irqSource(irqSource),
	.irqLevel(irqLevel));

`default_nettype wire

/* sim/ifeb_periph_model.sv */
`timescale 1ns/100ps
`default_nettype none

module ifeb_periph_model
	import ifeb_pkg::*;
(
	// Clock and reset
	input  wire logic                          ref_clk,
	input  wire logic                          reset_n,
	// Commands from the bench
	input  wire logic                          fire,
	input  wire logic [1:0]                    fireBank,
	input  wire logic [3:0]                    fireBit,
	input  wire logic [NUM_EXT-1:0]            pinSet,
	// Toward the controller
	output logic      [NUM_BANKS-1:0][REG_W-1:0] periphReq,
	output logic      [NUM_EXT-1:0]            extPin
);
	// A source pulses its request for one cycle; pins follow the bench a cycle late
	always_ff @(posedge ref_clk or negedge reset_n)
	begin
		if (!reset_n)
		begin
			periphReq <= '0;
			extPin    <= '0;
		end
		else
		begin
			periphReq <= '0;
			if (fire)
				periphReq[fireBank][fireBit] <= 1'b1;
			extPin <= pinSet;
		end
	end
endmodule

`default_nettype wire

/* sim/interrupt_flag_enable_bank_tb_top.sv */
`timescale 1ns/100ps
`default_nettype none

module interrupt_flag_enable_bank_tb_top;
	import ifeb_pkg::*;

	logic                            ref_clk, reset_n, psel, penable, pwrite, pready, pslverr, irq, err, fire;
	logic [ADDR_W-1:0]               paddr;
	logic [DATA_W-1:0]               pwdata, prdata, rd;
	logic [3:0]                      pstrb, fireBit;
	logic [1:0]                      fireBank;
	logic [NUM_BANKS-1:0][REG_W-1:0] periphReq;
	logic [NUM_EXT-1:0]              extPin, pinSet;
	logic [SRC_IDX_W-1:0]            irqSource;
	logic [PRIO_W-1:0]               irqLevel;
	int                              errTotal, checksDone;
	// Implemented-bit layouts worked out by hand, not from the design's masks
	localparam logic [ADDR_W-1:0] REG_ADDR [5] = '{OFF_FLAG0, OFF_FLAG1, OFF_FLAG3, OFF_FLAG4, OFF_ENABLE0};
	localparam logic [REG_W-1:0]  REG_MASK [5] = '{16'h3fef, 16'h20db, 16'h8600, 16'h0602, 16'h3fef};

	ifeb_intc dut_u (.ref_clk(ref_clk), .reset_n(reset_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.periphReq(periphReq), .extPin(extPin), .irq(irq), .irqSource(irqSource), .irqLevel(irqLevel));
	ifeb_periph_model partner_u (.ref_clk(ref_clk), .reset_n(reset_n), .fire(fire), .fireBank(fireBank),
		.fireBit(fireBit), .pinSet(pinSet), .periphReq(periphReq), .extPin(extPin));

	// Free-running clock
	always #5 ref_clk = ~ref_clk;

	////////////////////////////////////////////////////////////////
	// One bus transfer; no fixed latency assumed, the watchdog cuts a hang
	task automatic apbXfer(input logic wr, input logic [ADDR_W-1:0] addr, input logic [DATA_W-1:0] data);
		@(posedge ref_clk);
		psel    <= 1'b1;
		penable <= 1'b0;
		pwrite  <= wr;
		paddr   <= addr;
		pwdata  <= data;
		pstrb   <= 4'h3;
		@(posedge ref_clk);
		penable <= 1'b1;
		do @(posedge ref_clk); while (pready !== 1'b1);
		rd = prdata;
		err = pslverr;
		psel    <= 1'b0;
		penable <= 1'b0;
	endtask

	task automatic checkWord(input logic [DATA_W-1:0] got, input logic [DATA_W-1:0] exp);
		checksDone++;
		if (got !== exp)
		begin
			errTotal++;
			$display("MISMATCH t=%0t word got %h exp %h", $time, got, exp);
		end
	endtask

	task automatic checkBit(input logic got, input logic exp);
		checksDone++;
		if (got !== exp)
		begin
			errTotal++;
			$display("MISMATCH t=%0t bit got %b exp %b", $time, got, exp);
		end
	endtask

	// Ask the partner for a one-cycle request pulse
	task automatic pulseReq(input int bank, input int pos);
		@(posedge ref_clk);
		fire     <= 1'b1;
		fireBank <= 2'(bank);
		fireBit  <= 4'(pos);
		@(posedge ref_clk);
		fire <= 1'b0;
	endtask

	// Pin change, then room for the partner's one-cycle delay, edge pulse and flag update
	task automatic setPins(input logic [NUM_EXT-1:0] v);
		@(posedge ref_clk);
		pinSet <= v;
		repeat (4) @(posedge ref_clk);
	endtask

	task automatic summarize();
		if (errTotal == 0 && checksDone > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	////////////////////////////////////////////////////////////////
	// Main sequence
	initial
	begin
		{ref_clk, reset_n, psel, penable, pwrite, fire} = '0;
		{paddr, pwdata, pstrb, fireBank, fireBit, pinSet} = '0;
		errTotal = 0;
		checksDone = 0;
		repeat (5) @(posedge ref_clk);
		reset_n <= 1'b1;
		for (int i = 0; i < 5; i++)
		begin
			apbXfer(1'b0, REG_ADDR[i], '0);
			checkWord(rd, '0);
			apbXfer(1'b1, REG_ADDR[i], 32'hffffffff);
			apbXfer(1'b0, REG_ADDR[i], '0);
			checkWord(rd, {16'h0000, REG_MASK[i]});
			apbXfer(1'b1, REG_ADDR[i], '0);
			apbXfer(1'b0, REG_ADDR[i], '0);
			checkWord(rd, '0);
		end
		// Hole in the map: write dropped, read zero with error
		apbXfer(1'b1, 12'h008, 32'h0000ffff);
		apbXfer(1'b0, 12'h008, '0);
		checkWord(rd, '0);
		checkBit(err, 1'b1);
		// Every source position in turn, absent ones must stay clear
		for (int b = 0; b < 4; b++)
			for (int i = 0; i < 16; i++)
			begin
				pulseReq(b, i);
				apbXfer(1'b0, REG_ADDR[b], '0);
				checkWord(rd, {16'h0000, REG_MASK[b] & (16'h0001 << i)});
				apbXfer(1'b1, REG_ADDR[b], '0);
			end
		// Request gating by enable and priority
		pulseReq(0, 3);
		repeat (3) @(posedge ref_clk);
		checkBit(irq, 1'b0);
		apbXfer(1'b1, OFF_ENABLE0, 32'h0000_0008);
		repeat (3) @(posedge ref_clk);
		checkBit(irq, 1'b1);
		checkWord(32'(irqSource), 32'h3);
		checkWord(32'(irqLevel), 32'(PRIO_RESET));
		apbXfer(1'b1, OFF_PRIO_BASE, 32'h0000_7444);
		repeat (3) @(posedge ref_clk);
		checkWord(32'(irqLevel), 32'h7);
		apbXfer(1'b1, OFF_PRIO_BASE, 32'h0000_0444);
		repeat (3) @(posedge ref_clk);
		checkBit(irq, 1'b0);
		apbXfer(1'b1, OFF_PRIO_BASE, 32'h0000_4444);
		apbXfer(1'b1, OFF_FLAG0, '0);
		repeat (3) @(posedge ref_clk);
		checkBit(irq, 1'b0);
		// Pin zero: rising by default, then falling only
		setPins(3'h1);
		apbXfer(1'b0, OFF_FLAG0, '0);
		checkWord(rd, 32'h1);
		apbXfer(1'b1, OFF_FLAG0, '0);
		apbXfer(1'b1, OFF_POLARITY, 32'h1);
		setPins(3'h0);
		apbXfer(1'b0, OFF_FLAG0, '0);
		checkWord(rd, 32'h1);
		apbXfer(1'b1, OFF_FLAG0, '0);
		setPins(3'h1);
		apbXfer(1'b0, OFF_FLAG0, '0);
		checkWord(rd, 32'h0);
		checkBit(err, 1'b0);
		// Pins one and two rise while their polarity bits are still zero
		setPins(3'h7);
		apbXfer(1'b0, OFF_FLAG1, '0);
		checkWord(rd, 32'h0000_2010);
		apbXfer(1'b0, OFF_POLARITY, '0);
		checkWord(rd, 32'h0000_0001);
		// Priority fields read back; the field of an absent source stays zero
		apbXfer(1'b0, OFF_PRIO_BASE, '0);
		checkWord(rd, 32'h0000_4444);
		apbXfer(1'b0, OFF_PRIO_BASE + 12'h004, '0);
		checkWord(rd, 32'h0000_4440);
		summarize();
	end

	// Watchdog, far beyond the fewer than a thousand cycles the run needs
	initial
	begin
		repeat (20000) @(posedge ref_clk);
		errTotal++;
		summarize();
	end
endmodule

`default_nettype wire
